// file: rtl/converter_fault_supervisor.sv
// Purpose: decides how the buck converter answers its faults
// Assumes: fault inputs come from measurement logic on sys_clk
// Notes:   reset_n is the supply startup; only it clears a latch
// Function
// - two responses: automatic restart, and latch keeping the converter off
// - error counter counts fault restarts up to four
// - counter clears after error-free run time and on every supply startup
// - output faults auto-restart; after fourth failed restart, latch
// - open-output restart runs the current-setting procedure before restarting
// - input and overheat faults: wait in startup, auto-restart in normal
// - faults checked only in their marked modes; output faults only normal, open output in soft-start too
// - input undervoltage turns current off until startup minimum is met
// - undervoltage uses higher startup and lower operating threshold
// - input overvoltage turns current off until startup maximum is met
// - overvoltage uses lower startup and higher operating threshold
// - input voltage shutdowns leave the error counter unchanged
// - second-level overcurrent: immediate timed loop until off or cleared
// - every automatic restart except after overcurrent waits the fixed restart timeout; overcurrent waits its loop time
// - output undervoltage checked only after soft-start completes
// - open output when switch current takes too long to peak
`timescale 1ns/1ns
module converter_fault_supervisor
    import fault_sup_pkg::*;
#(
    parameter int ERR_CLR_CYC = ERR_CLR_CYC_DEF
)
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // measurement front end
    input  wire logic [VIN_W-1:0]  vin_meas,
    input  wire logic              output_undervoltage_fault,
    input  wire logic              output_overvoltage_fault,
    input  wire logic              output_overpower_fault,
    input  wire logic              internal_overheat_fault,
    input  wire logic              external_overheat_fault,
    input  wire logic              second_level_overcurrent,
    input  wire logic              switch_on,
    input  wire logic              peak_reached,
    // power stage control
    input  wire logic              softstart_done,
    input  wire logic              iset_done,
    output logic                   buck_enable,
    output logic                   iset_request,
    output logic                   latched,
    output logic                   irq
);
    typedef struct packed {
        sup_state_e       state;
        logic             buck_en;
        logic             iset_req;
        logic             latched;
        logic [2:0]       err_cnt;
        logic [31:0]      timer;
        logic [31:0]      clr_cnt;
        logic [OTO_W-1:0] on_cnt;
        logic             on_act;
        logic             enable;
        logic [VIN_W-1:0] vmin_st;
        logic [VIN_W-1:0] vmin_op;
        logic [VIN_W-1:0] vmax_st;
        logic [VIN_W-1:0] vmax_op;
        logic [OTO_W-1:0] open_to;
        logic [EV_W-1:0]  ev_stat;
        logic [EV_W-1:0]  ev_en;
        logic             irq;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } sup_s;

    sup_s            r;
    sup_s            n;
    vin_check_if     vif ();
    logic [EV_W-1:0] ev;
    logic            open_f;
    logic            heat_f;
    logic            wr;

    function automatic logic is_run(input sup_state_e s);
        is_run = (s == ST_RAMP) || (s == ST_RUN);
    endfunction

    function automatic logic [31:0] zx12(input logic [VIN_W-1:0] v);
        zx12 = {{(32-VIN_W){1'b0}}, v};
    endfunction

    // ************************************************************
    // input voltage window
    // ************************************************************
    assign vif.vin       = vin_meas;
    assign vif.min_start = r.vmin_st;
    assign vif.min_oper  = r.vmin_op;
    assign vif.max_start = r.vmax_st;
    assign vif.max_oper  = r.vmax_op;
    assign vif.oper      = (r.state == ST_RUN);

    vin_window u_win (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .bus     (vif.chk)
    );

    assign heat_f = internal_overheat_fault | external_overheat_fault;
    assign open_f = r.on_act && (r.on_cnt > r.open_to);
    assign wr     = psel & penable & pwrite & r.pready;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        n  = r;
        ev = '0;
        // apb: answer is ready in the first access cycle
        n.pready  = psel & ~penable;
        n.pslverr = 1'b0;
        if (psel & ~penable)
        begin
            unique case (paddr)
                ADDR_CTRL:     n.prdata = {31'h0000_0000, r.enable};
                ADDR_VMIN_ST:  n.prdata = zx12(r.vmin_st);
                ADDR_VMIN_OP:  n.prdata = zx12(r.vmin_op);
                ADDR_VMAX_ST:  n.prdata = zx12(r.vmax_st);
                ADDR_VMAX_OP:  n.prdata = zx12(r.vmax_op);
                ADDR_OPEN_TO:  n.prdata = {16'h0000, r.open_to};
                ADDR_STATUS:   n.prdata = {24'h0000_00, r.buck_en, r.latched,
                                           r.err_cnt, r.state};
                ADDR_IRQ_STAT: n.prdata = {23'h00_0000, r.ev_stat};
                ADDR_IRQ_CLR:  n.prdata = 32'h0000_0000;
                ADDR_IRQ_EN:   n.prdata = {23'h00_0000, r.ev_en};
                default:
                begin
                    n.prdata  = 32'h0000_0000;
                    n.pslverr = 1'b1;
                end
            endcase
        end
        if (wr)
        begin
            unique case (paddr)
                ADDR_CTRL:    n.enable  = pwdata[0];
                ADDR_VMIN_ST: n.vmin_st = pwdata[VIN_W-1:0];
                ADDR_VMIN_OP: n.vmin_op = pwdata[VIN_W-1:0];
                ADDR_VMAX_ST: n.vmax_st = pwdata[VIN_W-1:0];
                ADDR_VMAX_OP: n.vmax_op = pwdata[VIN_W-1:0];
                ADDR_OPEN_TO: n.open_to = pwdata[OTO_W-1:0];
                ADDR_IRQ_CLR: n.ev_stat = r.ev_stat & ~pwdata[EV_W-1:0];
                ADDR_IRQ_EN:  n.ev_en   = pwdata[EV_W-1:0];
                default:      n.enable  = r.enable;
            endcase
        end

        // open-output timer: time from switch on to current peak
        if (!is_run(r.state))
        begin
            n.on_act = 1'b0;
            n.on_cnt = '0;
        end
        else if (switch_on)
        begin
            n.on_act = 1'b1;
            n.on_cnt = '0;
        end
        else if (peak_reached)
            n.on_act = 1'b0;
        else if (r.on_act && (r.on_cnt != '1))
            n.on_cnt = r.on_cnt + 1'b1;

        // restart and latch decisions only in the run states; the wait holds on input and heat faults, the loop on overcurrent
        unique case (r.state)
            ST_OFF:
            begin
                if (r.enable)
                    n.state = ST_WAIT;
            end
            ST_WAIT:
            begin
                // startup thresholds must be met before current flows
                if (!vif.under && !vif.over && !heat_f)
                    n.state = ST_RAMP;
            end
            ST_RAMP, ST_RUN:
            begin
                if (second_level_overcurrent)
                begin
                    ev[EV_SECOND_LEVEL_OVERCURRENT] = 1'b1;
                    n.state     = ST_SECOND_LEVEL_OVERCURRENT;
                    n.timer     = 32'(SECOND_LEVEL_OVERCURRENT_LOOP_CYC - 1);
                end
                else if (open_f || ((r.state == ST_RUN) &&
                         (output_undervoltage_fault | output_overvoltage_fault |
                          output_overpower_fault)))
                begin
                    ev[EV_OPEN]   = open_f;
                    ev[EV_OUT_UV] = (r.state == ST_RUN) & output_undervoltage_fault;
                    ev[EV_OUT_OV] = (r.state == ST_RUN) & output_overvoltage_fault;
                    ev[EV_PWR]    = (r.state == ST_RUN) & output_overpower_fault;
                    if (r.err_cnt == RESTART_TRIES)
                    begin
                        ev[EV_LATCH] = 1'b1;
                        n.state      = ST_LATCH;
                        n.latched    = 1'b1;
                    end
                    else
                    begin
                        n.err_cnt = r.err_cnt + 3'h1;
                        n.timer   = 32'(ERR_RESTART_CYC - 1);
                        n.state   = open_f ? ST_ISET : ST_RESTART;
                    end
                end
                else if (vif.under || vif.over || heat_f)
                begin
                    // counter untouched on input voltage shutdowns
                    ev[EV_IN_UV] = vif.under;
                    ev[EV_IN_OV] = vif.over;
                    ev[EV_HEAT]  = heat_f;
                    n.timer      = 32'(ERR_RESTART_CYC - 1);
                    n.state      = (r.state == ST_RUN) ? ST_RESTART : ST_WAIT;
                end
                else if (r.state == ST_RAMP)
                begin
                    n.clr_cnt = '0;
                    if (softstart_done)
                        n.state = ST_RUN;
                end
                else if (r.clr_cnt == 32'(ERR_CLR_CYC - 1))
                begin
                    n.err_cnt = '0;
                    n.clr_cnt = '0;
                end
                else
                    n.clr_cnt = r.clr_cnt + 32'h0000_0001;
            end
            ST_ISET:
            begin
                if (iset_done)
                    n.state = ST_RESTART;
            end
            ST_RESTART:
            begin
                if (r.timer == '0)
                    n.state = ST_WAIT;
                else
                    n.timer = r.timer - 32'h0000_0001;
            end
            ST_SECOND_LEVEL_OVERCURRENT:
            begin
                if (r.timer != '0)
                    n.timer = r.timer - 32'h0000_0001;
                else if (second_level_overcurrent)
                    n.timer = 32'(SECOND_LEVEL_OVERCURRENT_LOOP_CYC - 1);
                else
                    n.state = ST_WAIT;
            end
            ST_LATCH:
                n.state = ST_LATCH;
        endcase
        // switching off ends every state except the latch
        if (!r.enable && (r.state != ST_LATCH))
            n.state = ST_OFF;
        n.buck_en  = is_run(n.state);
        n.iset_req = (n.state == ST_ISET);
        // hardware set wins over a software clear in the same cycle
        n.ev_stat  = n.ev_stat | ev;
        n.irq      = |(n.ev_stat & n.ev_en);
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r         <= '0;
            r.state   <= ST_OFF;
            r.vmin_st <= VMIN_ST_RST;
            r.vmin_op <= VMIN_OP_RST;
            r.vmax_st <= VMAX_ST_RST;
            r.vmax_op <= VMAX_OP_RST;
            r.open_to <= OPEN_TO_RST;
        end
        else
            r <= n;
    end

    assign prdata       = r.prdata;
    assign pready       = r.pready;
    assign pslverr      = r.pslverr;
    assign buck_enable  = r.buck_en;
    assign iset_request = r.iset_req;
    assign latched      = r.latched;
    assign irq          = r.irq;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_out_fault;
        r.state == ST_RUN && r.enable && !second_level_overcurrent && !open_f &&
        (output_undervoltage_fault | output_overvoltage_fault | output_overpower_fault);
    endsequence

    sequence s_restart_done;
        r.state == ST_RESTART && r.timer == '0 && r.enable;
    endsequence

    a_latch_off_hold: assert property (r.state == ST_LATCH |=> r.state == ST_LATCH [*8] ##0 !buck_enable) else $error("latch released");
    a_buck_run_only: assert property (buck_enable |-> is_run(r.state)) else $error("buck on outside run");
    a_count_limit: assert property (r.err_cnt <= RESTART_TRIES) else $error("error count beyond limit");
    a_latch_entry: assert property (s_out_fault and (r.err_cnt == RESTART_TRIES) |=> r.state == ST_LATCH && latched) else $error("no latch after tries");
    a_count_step: assert property (s_out_fault and (r.err_cnt < RESTART_TRIES) |=> r.err_cnt == $past(r.err_cnt) + 3'h1 && r.state == ST_RESTART) else $error("restart not counted");
    a_input_nocount: assert property (r.state == ST_RUN && vif.under && !second_level_overcurrent && !open_f && !(output_undervoltage_fault | output_overvoltage_fault | output_overpower_fault) |=> $stable(r.err_cnt) && !buck_enable) else $error("input fault touched count");
    a_open_iset: assert property (is_run(r.state) && r.enable && open_f && !second_level_overcurrent && r.err_cnt < RESTART_TRIES |=> iset_request) else $error("open restart skipped setup");
    a_second_level_overcurrent_now: assert property (is_run(r.state) && r.enable && second_level_overcurrent |=> r.state == ST_SECOND_LEVEL_OVERCURRENT && !buck_enable) else $error("overcurrent not immediate");
    a_restart_wait: assert property (s_restart_done |=> r.state == ST_WAIT) else $error("restart timeout not honoured");
    a_ramp_no_output_undervoltage_fault: assert property (r.state == ST_RAMP && r.enable && !open_f && !second_level_overcurrent && !vif.under && !vif.over && !heat_f |=> r.state != ST_RESTART && r.state != ST_LATCH) else $error("output fault checked in ramp");

endmodule

// file: rtl/fault_sup_pkg.sv
// Purpose: shared constants for the converter fault supervisor
// Assumes: 20 MHz system clock, 32-bit APB register access
// Notes:   times are kept in their own unit, cycle counts derive from them
package fault_sup_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_KHZ             = 20000;
    localparam int ERR_RESTART_TIME_US = 100;
    localparam int SECOND_LEVEL_OVERCURRENT_LOOP_TIME_US   = 50;
    localparam int ERR_CLR_TIME_MS     = 10;
    // least times round up to whole cycles
    localparam int ERR_RESTART_CYC     = (ERR_RESTART_TIME_US * CLK_KHZ + 999) / 1000;
    localparam int SECOND_LEVEL_OVERCURRENT_LOOP_CYC       = (SECOND_LEVEL_OVERCURRENT_LOOP_TIME_US * CLK_KHZ + 999) / 1000;
    localparam int ERR_CLR_CYC_DEF     = ERR_CLR_TIME_MS * CLK_KHZ;
    localparam logic [2:0] RESTART_TRIES = 3'h4;

    // ************************************************************
    // widths and register map
    // ************************************************************
    localparam int VIN_W  = 12;
    localparam int OTO_W  = 16;
    localparam int EV_W   = 9;
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_VMIN_ST   = 8'h04;
    localparam logic [7:0] ADDR_VMIN_OP   = 8'h08;
    localparam logic [7:0] ADDR_VMAX_ST   = 8'h0C;
    localparam logic [7:0] ADDR_VMAX_OP   = 8'h10;
    localparam logic [7:0] ADDR_OPEN_TO   = 8'h14;
    localparam logic [7:0] ADDR_STATUS    = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_CLR   = 8'h20;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h24;

    // reset values
    localparam logic [VIN_W-1:0] VMIN_ST_RST = 12'h0400;
    localparam logic [VIN_W-1:0] VMIN_OP_RST = 12'h0380;
    localparam logic [VIN_W-1:0] VMAX_ST_RST = 12'h0C00;
    localparam logic [VIN_W-1:0] VMAX_OP_RST = 12'h0C80;
    localparam logic [OTO_W-1:0] OPEN_TO_RST = 16'h0400;

    // event / interrupt bit positions
    localparam int EV_IN_UV  = 0;
    localparam int EV_IN_OV  = 1;
    localparam int EV_OUT_UV = 2;
    localparam int EV_OPEN   = 3;
    localparam int EV_OUT_OV = 4;
    localparam int EV_PWR    = 5;
    localparam int EV_HEAT   = 6;
    localparam int EV_SECOND_LEVEL_OVERCURRENT   = 7;
    localparam int EV_LATCH  = 8;

    // status register field positions
    localparam int ST_CNT_LSB = 3;
    localparam int ST_LATCHED = 6;
    localparam int ST_BUCK    = 7;

    typedef enum logic [2:0] {
        ST_OFF     = 3'b000,
        ST_WAIT    = 3'b001,
        ST_RAMP    = 3'b010,
        ST_RUN     = 3'b011,
        ST_ISET    = 3'b100,
        ST_RESTART = 3'b101,
        ST_SECOND_LEVEL_OVERCURRENT    = 3'b110,
        ST_LATCH   = 3'b111
    } sup_state_e;

endpackage

// file: rtl/vin_check_if.sv
// Purpose: carries input voltage and thresholds to the window checker
// Assumes: both ends on sys_clk
// Notes:   oper selects the operating thresholds instead of the startup ones
`timescale 1ns/1ns
interface vin_check_if;
    import fault_sup_pkg::*;
    logic [VIN_W-1:0] vin;
    logic [VIN_W-1:0] min_start;
    logic [VIN_W-1:0] min_oper;
    logic [VIN_W-1:0] max_start;
    logic [VIN_W-1:0] max_oper;
    logic             oper;
    logic             under;
    logic             over;
    modport sup (output vin, min_start, min_oper, max_start, max_oper, oper,
                 input under, over);
    modport chk (input vin, min_start, min_oper, max_start, max_oper, oper,
                 output under, over);
endinterface

// file: rtl/vin_window.sv
// Purpose: hysteretic input undervoltage / overvoltage comparison
// Assumes: vin is an ADC result already on sys_clk
// Notes:   results are registered, one cycle behind the inputs
`timescale 1ns/1ns
module vin_window
    import fault_sup_pkg::*;
(
    // clock and reset
    input  wire logic   sys_clk,
    input  wire logic   reset_n,
    // checker side of the voltage link
    vin_check_if.chk    bus
);
    typedef struct packed {
        logic under;
        logic over;
    } win_s;

    win_s r;
    win_s n;

    // ************************************************************
    // threshold pick
    // ************************************************************
    always_comb
    begin
        n = r;
        // startup thresholds are stricter so the converter cannot chatter
        if (bus.oper)
        begin
            n.under = bus.vin < bus.min_oper;
            n.over  = bus.vin > bus.max_oper;
        end
        else
        begin
            n.under = bus.vin < bus.min_start;
            n.over  = bus.vin > bus.max_start;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            r <= '0;
        else
            r <= n;
    end

    assign bus.under = r.under;
    assign bus.over  = r.over;

endmodule

// file: tb/buck_stage_model.sv
// Purpose: behavioural power stage and switch-current front end
// Assumes: shares sys_clk with the supervisor
// Notes:   open_load hides the current peak so the open check can fire
`timescale 1ns/1ns
module buck_stage_model
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // supervisor side
    input  wire logic buck_enable,
    input  wire logic iset_request,
    // scenario control
    input  wire logic open_load,
    // answers
    output logic      softstart_done,
    output logic      iset_done,
    output logic      switch_on,
    output logic      peak_reached
);
    // ********************
    // ramp, setting and switching counters
    // ********************
    logic [7:0] ss_cnt;
    logic [7:0] is_cnt;
    logic [5:0] sw_cnt;
    // soft-start drops with the enable, like a real ramp that restarts from zero
    assign softstart_done = (ss_cnt == 8'h14);
    assign iset_done      = (is_cnt == 8'h0A);
    assign switch_on      = buck_enable && (sw_cnt == 6'h01);
    assign peak_reached   = buck_enable && (sw_cnt == 6'h05) && !open_load;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ss_cnt <= 8'h00;
            is_cnt <= 8'h00;
            sw_cnt <= 6'h00;
        end
        else
        begin
            ss_cnt <= !buck_enable ? 8'h00 : (softstart_done ? ss_cnt : ss_cnt + 8'h01);
            is_cnt <= !iset_request ? 8'h00 : (iset_done ? is_cnt : is_cnt + 8'h01);
            sw_cnt <= buck_enable ? sw_cnt + 6'h01 : 6'h00;
        end
    end
endmodule

// file: tb/converter_fault_supervisor_tb_top.sv
// Purpose: self-checking bench for the converter fault supervisor
// Assumes: APB slave answers on its own time, restart time from the package
// Notes:   error-clear time shortened to CLR cycles to keep the run short
`timescale 1ns/1ns
module converter_fault_supervisor_tb_top;
    import fault_sup_pkg::*;
    localparam int CLR = 50;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} row_s;
    logic             sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, q;
    logic [VIN_W-1:0] vin;
    logic [2:0]       flt;
    logic [1:0]       heat;
    logic             ocp, open_load, ss, isd, swo, pk, buck, isr, latched, irq;
    int               n_mismatch, checked, ticks, gap, t0;
    row_s rows [11] = '{'{ADDR_CTRL, 32'h0, 1'b0}, '{ADDR_VMIN_ST, 32'(VMIN_ST_RST), 1'b0},
        '{ADDR_VMIN_OP, 32'(VMIN_OP_RST), 1'b0}, '{ADDR_VMAX_ST, 32'(VMAX_ST_RST), 1'b0},
        '{ADDR_VMAX_OP, 32'(VMAX_OP_RST), 1'b0}, '{ADDR_OPEN_TO, 32'(OPEN_TO_RST), 1'b0},
        '{ADDR_STATUS, 32'h0, 1'b0}, '{ADDR_IRQ_STAT, 32'h0, 1'b0},
        '{ADDR_IRQ_CLR, 32'h0, 1'b0}, '{ADDR_IRQ_EN, 32'h0, 1'b0}, '{8'h3C, 32'h0, 1'b1}};

    converter_fault_supervisor #(.ERR_CLR_CYC(CLR)) converter_fault_supervisor_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .vin_meas(vin),
        .output_undervoltage_fault(flt[2]), .output_overvoltage_fault(flt[1]),
        .output_overpower_fault(flt[0]), .internal_overheat_fault(heat[0]),
        .external_overheat_fault(heat[1]), .second_level_overcurrent(ocp),
        .switch_on(swo), .peak_reached(pk), .softstart_done(ss), .iset_done(isd),
        .buck_enable(buck), .iset_request(isr), .latched(latched), .irq(irq));
    buck_stage_model buck_stage_model_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .buck_enable(buck), .iset_request(isr), .open_load(open_load),
        .softstart_done(ss), .iset_done(isd), .switch_on(swo), .peak_reached(pk));

    // ********************
    // bus, compare and closing tasks
    // ********************
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task bus(input logic [7:0] a, input logic [31:0] d, input logic w);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task st(input logic [2:0] s, input logic [2:0] c);
        bus(ADDR_STATUS, 32'h0, 1'b0);
        chk(32'(q[5:0]), 32'({c, s}));
    endtask
    // bounded wait for the converter to come back on
    task won(input int n);
        gap = 0;
        while (buck !== 1'b1 && gap < n)
        begin
            @(posedge sys_clk);
            gap++;
        end
        chk(32'(buck), 1);
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // ceiling well above the roughly 20k cycles the sequence needs
    always @(posedge sys_clk)
    begin
        // non-blocking so that readers at the same edge all see one value
        ticks <= ticks + 1;
        if (ticks == 40000)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    // ********************
    // main sequence
    // ********************
    initial
    begin
        reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        vin = 12'h0800; flt = 0; heat = 0; ocp = 0; open_load = 0;
        n_mismatch = 0; checked = 0; ticks = 0;
        cyc(8);
        reset_n <= 1'b1;
        foreach (rows[i])
        begin
            bus(rows[i].a, 32'h0, 1'b0);
            chk(q, rows[i].d);
            chk(32'(e), 32'(rows[i].e));
        end
        // thresholds must take a write, then go back to their reset values
        for (int j = 1; j < 5; j++)
        begin
            bus(rows[j].a, 32'h0000_0ABC, 1'b1);
            bus(rows[j].a, 32'h0000_0000, 1'b0); chk(q, 32'h0000_0ABC);
            bus(rows[j].a, rows[j].d, 1'b1);
        end
        $display("reset values done");
        bus(ADDR_IRQ_EN, 32'h0000_01FF, 1'b1);
        bus(ADDR_CTRL, 32'h0000_0001, 1'b1);
        won(100);
        cyc(40); st(3'h3, 3'h0);
        vin <= 12'h03C0; cyc(10); st(3'h3, 3'h0);
        vin <= 12'h0300; cyc(5); chk(32'(buck), 0);
        st(3'h5, 3'h0);
        cyc(2100); st(3'h1, 3'h0);
        bus(ADDR_IRQ_STAT, 32'h0, 1'b0); chk(q, 32'h0000_0001);
        bus(ADDR_IRQ_CLR, 32'h0000_0001, 1'b1); cyc(2); chk(32'(irq), 0);
        vin <= 12'h03C0; cyc(10); st(3'h1, 3'h0);
        vin <= 12'h0800; heat <= 2'b01; cyc(10); st(3'h1, 3'h0);
        heat <= 2'b10; cyc(10); st(3'h1, 3'h0);
        heat <= 2'b00; won(50);
        cyc(40); vin <= 12'h0C40; cyc(10); st(3'h3, 3'h0);
        vin <= 12'h0D00; cyc(5); st(3'h5, 3'h0);
        cyc(2100); vin <= 12'h0C40; cyc(10); st(3'h1, 3'h0);
        vin <= 12'h0800; won(50);
        cyc(40); heat <= 2'b01; cyc(3); heat <= 2'b00; st(3'h5, 3'h0);
        won(2200);
        $display("input window done");
        for (int k = 0; k < 5; k++)
        begin
            cyc(2); flt <= 3'b100; cyc(2); flt <= 3'b000;
            st(3'h2, 3'(k));
            cyc(40); flt <= 3'b001 << (k % 3); cyc(2); flt <= 3'b000; t0 = ticks;
            if (k < 4)
            begin
                st(3'h5, 3'(k + 1));
                won(2200); chk(32'(ticks - t0 >= ERR_RESTART_CYC), 1);
            end
        end
        st(3'h7, 3'h4); chk(32'(latched), 1);
        bus(ADDR_IRQ_STAT, 32'h0, 1'b0); chk(32'(q[EV_LATCH]), 1); chk(32'(irq), 1);
        bus(ADDR_CTRL, 32'h0, 1'b1); bus(ADDR_CTRL, 32'h0000_0001, 1'b1);
        cyc(30); chk(32'(buck), 0); st(3'h7, 3'h4);
        reset_n <= 1'b0; cyc(2); reset_n <= 1'b1;
        st(3'h0, 3'h0); chk(32'(latched), 0);
        $display("restart and latch done");
        bus(ADDR_CTRL, 32'h0000_0001, 1'b1); won(100);
        cyc(40); flt <= 3'b010; cyc(2); flt <= 3'b000; st(3'h5, 3'h1);
        won(2200); cyc(100); st(3'h3, 3'h0);
        ocp <= 1'b1; cyc(3); bus(ADDR_STATUS, 32'h0, 1'b0); chk(32'(q[2:0]), 6);
        cyc(1100); bus(ADDR_STATUS, 32'h0, 1'b0); chk(32'(q[2:0]), 6);
        ocp <= 1'b0; won(1200);
        $display("clear and overcurrent done");
        bus(ADDR_OPEN_TO, 32'h0000_0028, 1'b1); open_load <= 1'b1;
        gap = 0;
        while (isr !== 1'b1 && gap < 300)
        begin
            @(posedge sys_clk);
            gap++;
        end
        chk(32'(isr), 1); chk(32'(buck), 0);
        bus(ADDR_STATUS, 32'h0, 1'b0); chk(32'(q[2:0]), 4);
        open_load <= 1'b0; cyc(20);
        bus(ADDR_STATUS, 32'h0, 1'b0); chk(32'(q[2:0]), 5);
        $display("open output done");
        finish_test();
    end
endmodule
